/* src/reset_cause_pkg.sv */
// Constants for the reset cause flag register and its event interrupt.
// Assumes a plain register port with byte-wide data in the low bits.
package reset_cause_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 8;
    localparam logic [3:0]  ADDR_FLAGS    = 4'h0;
    localparam logic [3:0]  ADDR_IRQ_STAT = 4'h1;
    localparam logic [3:0]  ADDR_IRQ_MASK = 4'h2;

    // ****************************************************************
    // Field positions of the flag register
    // ****************************************************************
    localparam int BIT_STK_OVF  = 7;
    localparam int BIT_STK_UNF  = 6;
    localparam int BIT_UNUSED   = 5;
    localparam int BIT_WDT_N    = 4;
    localparam int BIT_PIN_N    = 3;
    localparam int BIT_SOFT_N   = 2;
    localparam int BIT_POR_N    = 1;
    localparam int BIT_BOR_N    = 0;

    // Bits that exist; bit 5 reads as zero
    localparam logic [7:0] IMPL_MASK  = 8'hdf;
    // Power-on image: stack flags 0, bits 4..2 1, power-on and brown-out flags 0
    localparam logic [7:0] POR_VALUE  = 8'h1c;
    // Brown-out forces bits 7,6 to 0, bits 4..2 to 1, bit 0 to 0
    localparam logic [7:0] BOR_FORCE1 = 8'h1c;
    localparam logic [7:0] BOR_KEEP   = 8'h02;

    // ****************************************************************
    // Interrupt status bits: one per reset event
    // ****************************************************************
    localparam int NUM_EVT = 7;
    localparam int EVT_OVF = 0;
    localparam int EVT_UNF = 1;
    localparam int EVT_WDT = 2;
    localparam int EVT_PIN = 3;
    localparam int EVT_SFT = 4;
    localparam int EVT_POR = 5;
    localparam int EVT_BOR = 6;
    localparam logic [6:0] EVT_ZERO = 7'h00;

endpackage : reset_cause_pkg

/* src/event_irq.sv */
// Sticky event status with write-one-to-clear, mask and level interrupt.
// Assumes events are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module event_irq #(
    parameter int N = 7
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] evt,
    input  wire logic         clr_we,
    input  wire logic [N-1:0] clr_bits,
    input  wire logic         mask_we,
    input  wire logic [N-1:0] mask_wdata,
    output logic      [N-1:0] status_q,
    output logic      [N-1:0] mask_q,
    output logic              irq
);

    // Refuse a width that leaves no status bit to keep
    if (N < 1) begin : g_bad_n
        $error("event_irq needs at least one event");
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(clr_we ? clr_bits : '0)) | evt;
        end
    end

    // Mask register: one enables the bit onto the interrupt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= '0;
        end else if (mask_we) begin
            mask_q <= mask_wdata;
        end
    end

    assign irq = |(status_q & mask_q);

endmodule : event_irq

/* src/reset_cause_flag_register.sv */
// Reset cause flag register with event interrupt and register port.
// Assumes reset sources deliver one-cycle pulses already on clk; the
// power-on event is the asynchronous rst, brown-out events are pulses.
//
// Operation
// - Bit 7 set on stack overflow; read/write; zero after power/brown-out.
// - Bit 6 set on stack underflow; read/write; zero after power/brown-out.
// - Bit 5 unimplemented, ignores writes, reads zero.
// - Bit 4 cleared by watchdog reset; one means none or firmware set.
// - Bit 3 cleared by external pin reset; firmware writes one to rearm.
// - Bit 2 cleared by reset instruction; one means none or firmware set.
// - Bit 1 cleared on power-on; firmware must set it afterwards.
// - Bit 0 cleared on brown-out; one means none since firmware set it.
// - Power-on loads a fixed image, brown-out one that keeps bit 1; other resets change their bit.
// - Standard and low-power brown-out detectors clear the same bit.
`timescale 1ns/1ps
module reset_cause_flag_register (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       we,
    input  wire logic       re,
    output logic      [7:0] rdata,
    input  wire logic       stack_overflow_evt,
    input  wire logic       stack_underflow_evt,
    input  wire logic       watchdog_reset_evt,
    input  wire logic       pin_reset_evt,
    input  wire logic       soft_reset_evt,
    input  wire logic       brownout_evt,
    input  wire logic       low_power_brownout_evt,
    output logic      [7:0] reset_cause_flags,
    output logic            irq
);

    // ****************************************************************
    // Decode and flag register
    // ****************************************************************
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic       flags_we;
    logic       any_bor;
    logic       hw_evt;
    logic       por_seen_q;
    logic [6:0] evt;
    logic [6:0] irq_status;
    logic [6:0] irq_mask;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction : hit

    assign flags_we = we && hit(addr, reset_cause_pkg::ADDR_FLAGS);
    // Both detectors share the brown-out bit
    assign any_bor  = brownout_evt | low_power_brownout_evt;
    // Any hardware event that may touch the flags this cycle
    assign hw_evt   = stack_overflow_evt | stack_underflow_evt
                    | watchdog_reset_evt | pin_reset_evt
                    | soft_reset_evt | any_bor;

    // Next value: firmware write, then hardware events override it
    always_comb begin
        flags_d = flags_q;
        if (flags_we) begin
            flags_d = wdata & reset_cause_pkg::IMPL_MASK;
        end
        if (stack_overflow_evt) begin
            flags_d[reset_cause_pkg::BIT_STK_OVF] = 1'b1;
        end
        if (stack_underflow_evt) begin
            flags_d[reset_cause_pkg::BIT_STK_UNF] = 1'b1;
        end
        if (watchdog_reset_evt) begin
            flags_d[reset_cause_pkg::BIT_WDT_N] = 1'b0;
        end
        if (pin_reset_evt) begin
            flags_d[reset_cause_pkg::BIT_PIN_N] = 1'b0;
        end
        if (soft_reset_evt) begin
            flags_d[reset_cause_pkg::BIT_SOFT_N] = 1'b0;
        end
        // Brown-out image: keeps only the power-on bit
        if (any_bor) begin
            flags_d = (flags_q & reset_cause_pkg::BOR_KEEP)
                    | reset_cause_pkg::BOR_FORCE1;
        end
    end

    // Power-on is the async reset; it loads the power-on image
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= reset_cause_pkg::POR_VALUE;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Power-on event pulse for the interrupt, one cycle after release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_seen_q <= 1'b0;
        end else begin
            por_seen_q <= 1'b1;
        end
    end

    assign reset_cause_flags = flags_q;

    // ****************************************************************
    // Event interrupt
    // ****************************************************************
    always_comb begin
        evt = reset_cause_pkg::EVT_ZERO;
        evt[reset_cause_pkg::EVT_OVF] = stack_overflow_evt;
        evt[reset_cause_pkg::EVT_UNF] = stack_underflow_evt;
        evt[reset_cause_pkg::EVT_WDT] = watchdog_reset_evt;
        evt[reset_cause_pkg::EVT_PIN] = pin_reset_evt;
        evt[reset_cause_pkg::EVT_SFT] = soft_reset_evt;
        evt[reset_cause_pkg::EVT_POR] = ~por_seen_q;
        evt[reset_cause_pkg::EVT_BOR] = any_bor;
    end

    event_irq #(
        .N (reset_cause_pkg::NUM_EVT)
    ) u_irq (
        .clk        (clk),
        .rst        (rst),
        .evt        (evt),
        .clr_we     (we && hit(addr, reset_cause_pkg::ADDR_IRQ_STAT)),
        .clr_bits   (wdata[6:0]),
        .mask_we    (we && hit(addr, reset_cause_pkg::ADDR_IRQ_MASK)),
        .mask_wdata (wdata[6:0]),
        .status_q   (irq_status),
        .mask_q     (irq_mask),
        .irq        (irq)
    );

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (re) begin
            case (addr)
                reset_cause_pkg::ADDR_FLAGS:    rdata <= flags_q;
                reset_cause_pkg::ADDR_IRQ_STAT: rdata <= {1'b0, irq_status};
                reset_cause_pkg::ADDR_IRQ_MASK: rdata <= {1'b0, irq_mask};
                default:                        rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_ovf_set;
        @(posedge clk) disable iff (rst)
        stack_overflow_evt && !any_bor |=> flags_q[7];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set");

    property p_unf_set;
        @(posedge clk) disable iff (rst)
        stack_underflow_evt && !any_bor |=> flags_q[6];
    endproperty
    a_unf_set: assert property (p_unf_set)
        else $error("underflow flag not set");

    property p_bit5_zero;
        @(posedge clk) disable iff (rst)
        re && addr == reset_cause_pkg::ADDR_FLAGS |=> rdata[5] == 1'b0;
    endproperty
    a_bit5_zero: assert property (p_bit5_zero)
        else $error("bit 5 read nonzero");

    property p_wdt_clr;
        @(posedge clk) disable iff (rst)
        watchdog_reset_evt && !any_bor |=> !flags_q[4];
    endproperty
    a_wdt_clr: assert property (p_wdt_clr)
        else $error("watchdog flag not cleared");

    property p_pin_clr;
        @(posedge clk) disable iff (rst)
        pin_reset_evt && !any_bor |=> !flags_q[3];
    endproperty
    a_pin_clr: assert property (p_pin_clr)
        else $error("pin flag not cleared");

    property p_soft_clr;
        @(posedge clk) disable iff (rst)
        soft_reset_evt && !any_bor |=> !flags_q[2];
    endproperty
    a_soft_clr: assert property (p_soft_clr)
        else $error("soft reset flag not cleared");

    property p_por_keep;
        @(posedge clk) disable iff (rst)
        any_bor |=> flags_q[1] == $past(flags_q[1]);
    endproperty
    a_por_keep: assert property (p_por_keep)
        else $error("brown-out disturbed power-on flag");

    property p_bor_img;
        @(posedge clk) disable iff (rst)
        any_bor |=> (flags_q & ~reset_cause_pkg::BOR_KEEP)
            == reset_cause_pkg::BOR_FORCE1;
    endproperty
    a_bor_img: assert property (p_bor_img)
        else $error("brown-out image wrong");

    property p_hw_wins;
        @(posedge clk) disable iff (rst)
        flags_we && watchdog_reset_evt && !any_bor
            && wdata[4] |=> !flags_q[4];
    endproperty
    a_hw_wins: assert property (p_hw_wins)
        else $error("write beat hardware clear");

    // Register image: writes land, quiet cycles hold, resets load images
    property p_ovf_wins;
        @(posedge clk) disable iff (rst)
        flags_we && stack_overflow_evt && !any_bor
            && !wdata[reset_cause_pkg::BIT_STK_OVF]
            |=> flags_q[reset_cause_pkg::BIT_STK_OVF];
    endproperty
    a_ovf_wins: assert property (p_ovf_wins)
        else $error("write beat hardware set");

    property p_bit5_flag;
        @(posedge clk) disable iff (rst)
        flags_q[reset_cause_pkg::BIT_UNUSED] == 1'b0;
    endproperty
    a_bit5_flag: assert property (p_bit5_flag)
        else $error("bit 5 of flags set");

    property p_wr_land;
        @(posedge clk) disable iff (rst)
        flags_we && !hw_evt
            |=> flags_q == ($past(wdata) & reset_cause_pkg::IMPL_MASK);
    endproperty
    a_wr_land: assert property (p_wr_land)
        else $error("flag write did not land");

    // Without a write or event every flag keeps its value
    property p_hold;
        @(posedge clk) disable iff (rst)
        !flags_we && !hw_evt |=> $stable(flags_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("flags changed without cause");

    property p_por_img;
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> flags_q == reset_cause_pkg::POR_VALUE;
    endproperty
    a_por_img: assert property (p_por_img)
        else $error("power-on image wrong");

    property p_por_evt;
        @(posedge clk) disable iff (rst)
        $rose(por_seen_q) |-> irq_status[reset_cause_pkg::EVT_POR];
    endproperty
    a_por_evt: assert property (p_por_evt)
        else $error("power-on event not recorded");

    property p_stk_bor;
        @(posedge clk) disable iff (rst)
        any_bor |=> !flags_q[reset_cause_pkg::BIT_STK_OVF]
            && !flags_q[reset_cause_pkg::BIT_STK_UNF];
    endproperty
    a_stk_bor: assert property (p_stk_bor)
        else $error("stack flags survived brown-out");

    property p_lp_bor;
        @(posedge clk) disable iff (rst)
        low_power_brownout_evt |=> !flags_q[reset_cause_pkg::BIT_BOR_N];
    endproperty
    a_lp_bor: assert property (p_lp_bor)
        else $error("low-power brown-out not recorded");

    property p_bor_clr;
        @(posedge clk) disable iff (rst)
        brownout_evt |=> !flags_q[reset_cause_pkg::BIT_BOR_N];
    endproperty
    a_bor_clr: assert property (p_bor_clr)
        else $error("brown-out not recorded");

    property p_pin_rearm;
        @(posedge clk) disable iff (rst)
        flags_we && wdata[reset_cause_pkg::BIT_PIN_N] && !hw_evt
            |=> flags_q[reset_cause_pkg::BIT_PIN_N];
    endproperty
    a_pin_rearm: assert property (p_pin_rearm)
        else $error("pin flag not rearmed");

    property p_wdt_rearm;
        @(posedge clk) disable iff (rst)
        flags_we && wdata[reset_cause_pkg::BIT_WDT_N] && !hw_evt
            |=> flags_q[reset_cause_pkg::BIT_WDT_N];
    endproperty
    a_wdt_rearm: assert property (p_wdt_rearm)
        else $error("watchdog flag not rearmed");

    property p_soft_rearm;
        @(posedge clk) disable iff (rst)
        flags_we && wdata[reset_cause_pkg::BIT_SOFT_N] && !hw_evt
            |=> flags_q[reset_cause_pkg::BIT_SOFT_N];
    endproperty
    a_soft_rearm: assert property (p_soft_rearm)
        else $error("soft reset flag not rearmed");

    // Read data of the flag place is the image of the strobe cycle
    property p_rd_flags;
        @(posedge clk) disable iff (rst)
        re && addr == reset_cause_pkg::ADDR_FLAGS
            |=> rdata == $past(flags_q);
    endproperty
    a_rd_flags: assert property (p_rd_flags)
        else $error("flag read data wrong");

endmodule : reset_cause_flag_register

/* testbench/test_reset_cause_flag_register.sv */
// Self-checking bench for the reset cause flag register.
// Assumes the register port and the event pulses share clk.
`timescale 1ns/1ps
module test_reset_cause_flag_register;
    logic       clk;
    logic       rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
    logic [7:0] rdata;
    logic [6:0] ev;
    logic [7:0] flags;
    logic       irq;
    logic [7:0] got;
    logic [7:0] base;
    logic [7:0] want;
    logic [6:0] msk;
    int         err_count;
    int         checks;
    int         k;

    reset_cause_flag_register i_reset_cause_flag_register (
        .clk                    (clk),
        .rst                    (rst),
        .addr                   (addr),
        .wdata                  (wdata),
        .we                     (we),
        .re                     (re),
        .rdata                  (rdata),
        .stack_overflow_evt     (ev[0]),
        .stack_underflow_evt    (ev[1]),
        .watchdog_reset_evt     (ev[2]),
        .pin_reset_evt          (ev[3]),
        .soft_reset_evt         (ev[4]),
        .brownout_evt           (ev[5]),
        .low_power_brownout_evt (ev[6]),
        .reset_cause_flags      (flags),
        .irq                    (irq)
    );

    // ****************************************************************
    // Expectations
    // ****************************************************************
    // Flag image after one event pulse; brown-out keeps only bit 1
    function automatic logic [7:0] exp_flags(logic [7:0] f, int idx);
        case (idx)
            0: return f | 8'h80;
            1: return f | 8'h40;
            2: return f & 8'hef;
            3: return f & 8'hf7;
            4: return f & 8'hfb;
            default: return {5'h07, f[1], 1'b0} & 8'h1e;
        endcase
    endfunction : exp_flags

    // Both brown-out detectors share one status bit
    function automatic logic [6:0] exp_stat(int idx);
        logic [6:0] s;
        s = 7'h00;
        s[idx < 5 ? idx : reset_cause_pkg::EVT_BOR] = 1'b1;
        return s;
    endfunction : exp_stat

    // ****************************************************************
    // Bus, compare and closing tasks
    // ****************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        we    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        we    <= 1'b0;
        #1; // Callers look at outputs only once the write has landed
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic pulse(input int idx);
        @(posedge clk);
        ev <= 7'h01 << idx;
        @(posedge clk);
        ev <= 7'h00;
        #1;
    endtask : pulse

    task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Clock, hang guard and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        rst = 1'b1; we = 1'b0; re = 1'b0; addr = 4'h0;
        wdata = 8'h00; ev = 7'h00; err_count = 0; checks = 0;
        void'($urandom(88));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk8("flags", reset_cause_pkg::POR_VALUE, flags);
        rd(4'h1, got);
        chk8("irq_status", 8'h20, got);
        rd(4'h2, got);
        chk8("irq_mask", 8'h00, got);
        $display("test reset done");
        // Bit 5 ignored, unmapped places refused
        wr(4'h0, 8'hff);
        rd(4'h0, got);
        chk8("flags_read", 8'hdf, got);
        wr(4'h7, 8'h00);
        rd(4'h5, got);
        chk8("unmapped", 8'h00, got);
        chk8("flags", 8'hdf, flags);
        $display("test access done");
        // Every event, random start image, alternating mask
        wr(4'h1, 8'h7f);
        for (k = 0; k < 14; k++) begin
            base = 8'($urandom()) & reset_cause_pkg::IMPL_MASK;
            msk  = (k % 2) ? 7'h7f : 7'h00;
            wr(4'h2, {1'b0, msk});
            wr(4'h0, base);
            pulse(k % 7);
            want = exp_flags(base, k % 7);
            chk8("flags", want, flags);
            if (k % 7 >= 5) begin
                chk1("brownout_flag", 1'b0, flags[0]);
            end
            chk1("irq", |(exp_stat(k % 7) & msk), irq);
            rd(4'h1, got);
            chk8("irq_status", {1'b0, exp_stat(k % 7)}, got);
            wr(4'h1, 8'h7f);
            chk1("irq", 1'b0, irq);
        end
        $display("test events done");
        // Hardware set and clear beat a coincident firmware write
        @(posedge clk);
        we <= 1'b1; addr <= 4'h0; wdata <= 8'h7f; ev <= 7'h05;
        @(posedge clk);
        we <= 1'b0; ev <= 7'h00;
        #1;
        chk8("flags", 8'hcf, flags);
        $display("test priority done");
        // Second power-on in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk8("flags", reset_cause_pkg::POR_VALUE, flags);
        chk1("irq", 1'b0, irq);
        rd(4'h1, got);
        chk8("irq_status", 8'h20, got);
        $display("test rereset done");
        print_verdict();
    end
endmodule : test_reset_cause_flag_register
